/* File: verilog/xrt_pkg.sv */
`default_nettype none
package xrt_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_LOW = 8'hE1;
  localparam logic [7:0] IDX_HIGH = 8'hE2;
  localparam logic [7:0] IDX_CTRL = 8'hE3;
  localparam logic [7:0] IDX_SKIP = 8'hE4;
  localparam logic [7:0] IDX_MODE = 8'hE5;
  localparam logic [7:0] IDX_STATUS = 8'hE6;

  // Field positions, route_enable_low
  localparam int LOW_CMP1_ASYNC = 7;
  localparam int LOW_CMP1_SYNC = 6;
  localparam int LOW_CMP0_ASYNC = 5;
  localparam int LOW_CMP0_SYNC = 4;
  localparam int LOW_SYSCLK = 3;
  localparam int LOW_TWOWIRE = 2;
  localparam int LOW_SERIF_A = 1;
  localparam int LOW_UART = 0;
  // Field positions, route_enable_high
  localparam int HIGH_UNUSED = 7;
  localparam int HIGH_SERIF_B = 6;
  localparam int HIGH_TIMER_ONE = 5;
  localparam int HIGH_TIMER_ZERO = 4;
  localparam int HIGH_COUNT_IN = 3;
  localparam logic [7:0] HIGH_WRITE_MASK = 8'h7F;
  // Field positions, control, mode and status
  localparam int CTRL_WEAK_PULL_DIS = 7;
  localparam int CTRL_GLOBAL_EN = 6;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC0;
  localparam int MODE_SERIF_A_FOUR = 0;
  localparam int MODE_SERIF_B_FOUR = 1;
  localparam int STATUS_UNPLACED = 8;

  // Reset values
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [14:0] SKIP_RESET = 15'h0000;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pins P0.0 to P1.6, then functions in priority order
  localparam int PIN_COUNT = 15;
  localparam int FN_COUNT = 26;
  localparam int FN_W = 5;
  localparam int FIXED_COUNT = 6;
  localparam int FN_SCK_A = 6;
  localparam int FN_NSS_A = 9;
  localparam int FN_SDA = 10;
  localparam int FN_SCL = 11;
  localparam int FN_CAPTURE_OUT_FIRST = 17;
  localparam int CEX_MAX = 6;
  // Fixed pins of uart (P0.4, P0.5) and serif_b (P1.0 to P1.3)
  localparam logic [5:0][3:0] FIXED_PIN = {4'hB, 4'hA, 4'h9, 4'h8, 4'h5, 4'h4};
  // Code 0 on a pin means no routed function
  localparam logic [FN_W-1:0] FN_NONE = 5'h00;

  // Outcome of one pass of the priority decoder
  typedef struct packed {
    logic [PIN_COUNT-1:0][FN_W-1:0] func;
    logic [4:0] used;
    logic unplaced;
  } xrt_map_type;

endpackage : xrt_pkg
`default_nettype wire

/* File: verilog/xrt_crossbar.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module xrt_crossbar (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [xrt_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [xrt_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [xrt_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [xrt_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [xrt_pkg::PIN_COUNT-1:0][xrt_pkg::FN_W-1:0] pin_func_o,
  output logic [xrt_pkg::PIN_COUNT-1:0] pin_drive_en_o,
  output logic [xrt_pkg::PIN_COUNT-1:0] pin_open_drain_o,
  output logic weak_pull_disable_o
);
  import xrt_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ctrl;
    logic [14:0] skip;
    logic [1:0] mode;
    logic awready;
    logic wready;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    xrt_map_type map;
    logic [PIN_COUNT-1:0] drive;
    logic [PIN_COUNT-1:0] od;
  } xrt_state_type;

  xrt_state_type state_q; // Registered state
  xrt_state_type state_d; // Next state
  xrt_map_type map_now; // Decoder result from current registers

  // Word decode; low two address bits are ignored
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    addr_is = (addr[ADDR_W-1:2] == {2'h0, idx});
  endfunction : addr_is

  // Enables of all functions, in priority order
  function automatic logic [FN_COUNT-1:0] fn_enables(input logic [7:0] low, input logic [7:0] high,
                                                     input logic [1:0] mode);
    logic [FN_COUNT-1:0] en;
    en = '0;
    en[0] = low[LOW_UART];
    en[1] = low[LOW_UART];
    en[2] = high[HIGH_SERIF_B];
    en[3] = high[HIGH_SERIF_B];
    en[4] = high[HIGH_SERIF_B];
    en[5] = high[HIGH_SERIF_B] && mode[MODE_SERIF_B_FOUR];
    en[6] = low[LOW_SERIF_A];
    en[7] = low[LOW_SERIF_A];
    en[8] = low[LOW_SERIF_A];
    en[9] = low[LOW_SERIF_A] && mode[MODE_SERIF_A_FOUR];
    en[10] = low[LOW_TWOWIRE];
    en[11] = low[LOW_TWOWIRE];
    en[12] = low[LOW_CMP0_SYNC];
    en[13] = low[LOW_CMP0_ASYNC];
    en[14] = low[LOW_CMP1_SYNC];
    en[15] = low[LOW_CMP1_ASYNC];
    en[16] = low[LOW_SYSCLK];
    // Reserved 111 routes no capture output at all
    for (int k = 0; k < CEX_MAX; k++) begin
      en[FN_CAPTURE_OUT_FIRST + k] = (high[2:0] != 3'h7) && (int'(high[2:0]) > k);
    end
    en[23] = high[HIGH_COUNT_IN];
    en[24] = high[HIGH_TIMER_ZERO];
    en[25] = high[HIGH_TIMER_ONE];
    fn_enables = en;
  endfunction : fn_enables

  // Priority decoder: fixed pins first, then lowest free pin
  function automatic xrt_map_type decode(input logic [FN_COUNT-1:0] en, input logic [14:0] skip);
    xrt_map_type m;
    logic [PIN_COUNT-1:0] taken;
    logic placed;
    m = '0;
    taken = skip;
    placed = 1'b0;
    // Fixed functions ignore the skip mask; software keeps those clear
    for (int f = 0; f < FIXED_COUNT; f++) begin
      if (en[f]) begin
        m.func[FIXED_PIN[f]] = FN_W'(f + 1);
        taken[FIXED_PIN[f]] = 1'b1;
      end
    end
    for (int f = FIXED_COUNT; f < FN_COUNT; f++) begin
      if (en[f]) begin
        placed = 1'b0;
        for (int p = 0; p < PIN_COUNT; p++) begin
          // First unskipped, unassigned pin wins
          if (!placed && !taken[p]) begin
            m.func[p] = FN_W'(f + 1);
            taken[p] = 1'b1;
            placed = 1'b1;
          end
        end
        // Out of pins: the function is dropped and the unplaced flag is set
        if (!placed) begin
          m.unplaced = 1'b1;
        end
      end
    end
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (m.func[p] != FN_NONE) begin
        m.used = m.used + 5'h01;
      end
    end
    decode = m;
  endfunction : decode

  // Decoder from the registers as they stand now
  always_comb begin
    map_now = decode(fn_enables(state_q.low, state_q.high, state_q.mode), state_q.skip);
  end

  // All next-state logic
  always_comb begin
    state_d = state_q;
    if (!nrst_i) begin
      state_d = '0;
      state_d.low = LOW_RESET;
      state_d.high = HIGH_RESET;
      state_d.ctrl = CTRL_RESET;
      state_d.skip = SKIP_RESET;
      state_d.mode = MODE_RESET;
      state_d.awready = 1'b1;
      state_d.wready = 1'b1;
      state_d.arready = 1'b1;
    end else begin
      // Address and data are taken in either order
      if (state_q.awready && s_axi_awvalid_i) begin
        state_d.awready = 1'b0;
        state_d.awaddr = s_axi_awaddr_i;
      end
      if (state_q.wready && s_axi_wvalid_i) begin
        state_d.wready = 1'b0;
        state_d.wdata = s_axi_wdata_i;
        state_d.wstrb = s_axi_wstrb_i;
      end
      // Both halves held: commit and answer
      if (!state_q.awready && !state_q.wready && !state_q.bvalid) begin
        state_d.bvalid = 1'b1;
        state_d.bresp = RESP_OKAY;
        if (addr_is(state_q.awaddr, IDX_LOW)) begin
          if (state_q.wstrb[0]) begin
            state_d.low = state_q.wdata[7:0];
          end
        end else if (addr_is(state_q.awaddr, IDX_HIGH)) begin
          // Top bit never stores
          if (state_q.wstrb[0]) begin
            state_d.high = state_q.wdata[7:0] & HIGH_WRITE_MASK;
          end
        end else if (addr_is(state_q.awaddr, IDX_CTRL)) begin
          if (state_q.wstrb[0]) begin
            state_d.ctrl = state_q.wdata[7:0] & CTRL_WRITE_MASK;
          end
        end else if (addr_is(state_q.awaddr, IDX_SKIP)) begin
          if (state_q.wstrb[0]) begin
            state_d.skip[7:0] = state_q.wdata[7:0];
          end
          if (state_q.wstrb[1]) begin
            state_d.skip[14:8] = state_q.wdata[14:8];
          end
        end else if (addr_is(state_q.awaddr, IDX_MODE)) begin
          if (state_q.wstrb[0]) begin
            state_d.mode = state_q.wdata[1:0];
          end
        end else if (!addr_is(state_q.awaddr, IDX_STATUS)) begin
          // Unmapped word
          state_d.bresp = RESP_SLVERR;
        end
      end
      // Response taken: reopen both channels
      if (state_q.bvalid && s_axi_bready_i) begin
        state_d.bvalid = 1'b0;
        state_d.awready = 1'b1;
        state_d.wready = 1'b1;
      end
      // Read path, one outstanding
      if (state_q.arready && s_axi_arvalid_i) begin
        state_d.arready = 1'b0;
        state_d.rvalid = 1'b1;
        state_d.rresp = RESP_OKAY;
        state_d.rdata = '0;
        if (addr_is(s_axi_araddr_i, IDX_LOW)) begin
          state_d.rdata[7:0] = state_q.low;
        end else if (addr_is(s_axi_araddr_i, IDX_HIGH)) begin
          state_d.rdata[7:0] = state_q.high & HIGH_WRITE_MASK;
        end else if (addr_is(s_axi_araddr_i, IDX_CTRL)) begin
          state_d.rdata[7:0] = state_q.ctrl;
        end else if (addr_is(s_axi_araddr_i, IDX_SKIP)) begin
          state_d.rdata[14:0] = state_q.skip;
        end else if (addr_is(s_axi_araddr_i, IDX_MODE)) begin
          state_d.rdata[1:0] = state_q.mode;
        end else if (addr_is(s_axi_araddr_i, IDX_STATUS)) begin
          // Shows what the decoder produced last cycle
          state_d.rdata[4:0] = state_q.map.used;
          state_d.rdata[STATUS_UNPLACED] = state_q.map.unplaced;
        end else begin
          state_d.rresp = RESP_SLVERR;
        end
      end
      if (state_q.rvalid && s_axi_rready_i) begin
        state_d.rvalid = 1'b0;
        state_d.arready = 1'b1;
      end
      // Pin view registered once, so a write lands one cycle later
      state_d.map = map_now;
      for (int p = 0; p < PIN_COUNT; p++) begin
        state_d.drive[p] = state_q.ctrl[CTRL_GLOBAL_EN] && (map_now.func[p] != FN_NONE);
        state_d.od[p] = (map_now.func[p] == FN_W'(FN_SDA + 1)) ||
                        (map_now.func[p] == FN_W'(FN_SCL + 1));
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    state_q <= state_d;
  end

  // Outputs straight from the record
  assign s_axi_awready_o = state_q.awready;
  assign s_axi_wready_o = state_q.wready;
  assign s_axi_bresp_o = state_q.bresp;
  assign s_axi_bvalid_o = state_q.bvalid;
  assign s_axi_arready_o = state_q.arready;
  assign s_axi_rdata_o = state_q.rdata;
  assign s_axi_rresp_o = state_q.rresp;
  assign s_axi_rvalid_o = state_q.rvalid;
  assign pin_func_o = state_q.map.func;
  assign pin_drive_en_o = state_q.drive;
  assign pin_open_drain_o = state_q.od;
  assign weak_pull_disable_o = state_q.ctrl[CTRL_WEAK_PULL_DIS];

  // Checking helpers: which functions appear, and in what order
  logic [FN_COUNT-1:0] fn_seen; // Functions present on some pin
  logic order_ok; // Dynamic functions ascend with pin number
  logic [FN_COUNT-1:0] en_now; // Enables of current registers
  logic od_match; // Open drain flags sit exactly on two-wire pins
  always_comb begin
    logic [FN_W-1:0] last;
    last = FN_NONE;
    fn_seen = '0;
    order_ok = 1'b1;
    od_match = 1'b1;
    for (int p = 0; p < PIN_COUNT; p++) begin
      // Flag and map come from the same edge, so they must agree pin by pin
      if (pin_open_drain_o[p] != ((state_q.map.func[p] == FN_W'(FN_SDA + 1)) ||
                                  (state_q.map.func[p] == FN_W'(FN_SCL + 1)))) begin
        od_match = 1'b0;
      end
      if (state_q.map.func[p] != FN_NONE) begin
        fn_seen[int'(state_q.map.func[p]) - 1] = 1'b1;
        if (int'(state_q.map.func[p]) > FIXED_COUNT) begin
          if (state_q.map.func[p] < last) begin
            order_ok = 1'b0;
          end
          last = state_q.map.func[p];
        end
      end
    end
    en_now = fn_enables(state_q.low, state_q.high, state_q.mode);
  end

  // Write commit sequence
  sequence s_write_held;
    !state_q.awready && !state_q.wready && !state_q.bvalid;
  endsequence

  a_write_answer: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_write_held |=> s_axi_bvalid_o) else $error("write not answered");
  a_uart_fixed: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(state_q.low[LOW_UART]) |-> (pin_func_o[4] == 5'h01) && (pin_func_o[5] == 5'h02))
    else $error("uart not on its fixed pins");
  a_high_top_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !state_q.high[HIGH_UNUSED]) else $error("unused bit stored");
  a_serif_b_pins: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(state_q.high[HIGH_SERIF_B]) |-> (pin_func_o[8] == 5'h03) && (pin_func_o[9] == 5'h04) &&
    (pin_func_o[10] == 5'h05)) else $error("serif_b lines misplaced");
  a_serif_b_select: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ((pin_func_o[11] == 5'h06) == $past(state_q.high[HIGH_SERIF_B] && state_q.mode[MODE_SERIF_B_FOUR])))
    else $error("serif_b select pin wrong");
  a_all_placed: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    !state_q.map.unplaced |-> (fn_seen == $past(en_now)))
    else $error("enabled set differs from routed set");
  a_capture_none: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ($past(state_q.high[2:0]) == 3'h0 || $past(state_q.high[2:0]) == 3'h7) |-> (fn_seen[22:17] == 6'h00))
    else $error("capture output routed while none selected");
  a_priority_order: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    order_ok) else $error("routing out of priority order");
  a_drive_gated: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !$past(state_q.ctrl[CTRL_GLOBAL_EN]) |-> (pin_drive_en_o == 15'h0000))
    else $error("driver enabled while crossbar off");
  // Open drain flags reflect the registers of one cycle back, like the map
  a_twowire_od: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(state_q.low[LOW_TWOWIRE] && state_q.skip == 15'h0000) |-> $countones(pin_open_drain_o) == 2)
    else $error("two-wire pins not open drain");
  a_od_on_twowire: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    od_match) else $error("open drain flag off the two-wire pins");

endmodule : xrt_crossbar
`default_nettype wire

/* File: verif/xrt_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Board side of the port pins: pull-ups on open-drain lines, weak pull-ups elsewhere unless disabled
module xrt_pad_model (
  input wire logic core_clk_i,
  input wire logic [14:0] drive_en_i,
  input wire logic [14:0] open_drain_i,
  input wire logic weak_pull_disable_i,
  input wire logic [14:0] level_i,
  output logic [14:0] pad_o
);
  logic [14:0] last_q; // Pad levels of the previous cycle
  // Pad level per pin; a floating pad with no pull never keeps its old value
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      if (drive_en_i[i] && !(open_drain_i[i] && level_i[i])) begin
        pad_o[i] = level_i[i]; // Pin actively driven
      end else if (open_drain_i[i] || !weak_pull_disable_i) begin
        pad_o[i] = 1'b1; // Pull-up holds the line high
      end else begin
        pad_o[i] = ~last_q[i]; // Floating, so no trustworthy level
      end
    end
  end
  // Remember levels so a floating pad can flip
  always_ff @(posedge core_clk_i) begin
    last_q <= pad_o;
  end
endmodule : xrt_pad_model
`default_nettype wire

/* File: verif/xrt_crossbar_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module xrt_crossbar_bench;
  import xrt_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic resp_ready = 1'b1; // Master always accepts answers
  logic awready, wready, bvalid, arready, rvalid, weak_dis;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [PIN_COUNT-1:0][FN_W-1:0] pin_func;
  logic [PIN_COUNT-1:0] drive_en, open_drain, pads;
  logic [PIN_COUNT-1:0][FN_W-1:0] exp_map; // Expected function per pin
  int num_errors = 0;
  int total_checks = 0;

  xrt_crossbar i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(resp_ready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(resp_ready), .pin_func_o(pin_func), .pin_drive_en_o(drive_en),
    .pin_open_drain_o(open_drain), .weak_pull_disable_o(weak_dis));

  // Peripherals drive every routed pin low, so driven pads read 0
  xrt_pad_model i_pads (.core_clk_i(core_clk_i), .drive_en_i(drive_en), .open_drain_i(open_drain),
    .weak_pull_disable_i(weak_dis), .level_i(15'h0000), .pad_o(pads));

  // 25 MHz core clock
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Verdict and end of run, also reached by any timeout
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Byte address is four times the register index
  function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : adr

  // One write; address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, aw_hit, w_hit, b_ok;
    logic [1:0] got;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    got = 2'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready looked at mid-cycle where it has settled; the transfer is the next rising edge
    for (int n = 0; n < 40 && !(aw_ok && w_ok); n++) begin
      @(negedge core_clk_i);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge core_clk_i);
      if (aw_hit) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Response captured while it stands; bready is always high, so it goes at the next edge
    for (int n = 0; n < 40 && !b_ok; n++) begin
      @(negedge core_clk_i);
      if (bvalid) begin
        b_ok = 1'b1;
        got = bresp;
      end
      @(posedge core_clk_i);
    end
    if (!(aw_ok && w_ok && b_ok)) begin
      $display("[FAIL] %0t write not answered", $time);
      num_errors++;
      report_and_stop();
    end
    `CHK(got, er)
  endtask : axi_wr

  // One read, answer compared with the expectation
  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, ar_hit, r_ok;
    logic [DATA_W-1:0] got_d;
    logic [1:0] got_r;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    got_d = '0;
    got_r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 40 && !ar_ok; n++) begin
      @(negedge core_clk_i);
      ar_hit = arvalid && arready;
      @(posedge core_clk_i);
      if (ar_hit) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    // Data taken while rvalid stands, handshake at the following edge
    for (int n = 0; n < 40 && !r_ok; n++) begin
      @(negedge core_clk_i);
      if (rvalid) begin
        r_ok = 1'b1;
        got_d = rdata;
        got_r = rresp;
      end
      @(posedge core_clk_i);
    end
    if (!(ar_ok && r_ok)) begin
      $display("[FAIL] %0t read not answered", $time);
      num_errors++;
      report_and_stop();
    end
    `CHK(got_d, ed)
    `CHK(got_r, er)
  endtask : axi_rd

  // Consecutive codes on consecutive pins
  task automatic put_run(input int pin, input int code, input int cnt);
    for (int k = 0; k < cnt; k++) exp_map[pin + k] = FN_W'(code + k);
  endtask : put_run

  // Pin outputs one cycle on from the last write, looked at mid-cycle
  task automatic chk_pins(input logic ge);
    logic [PIN_COUNT-1:0] de;
    @(negedge core_clk_i);
    for (int i = 0; i < PIN_COUNT; i++) de[i] = (exp_map[i] !== FN_NONE) && ge;
    `CHK(pin_func, exp_map)
    `CHK(drive_en, de)
    @(posedge core_clk_i);
  endtask : chk_pins

  task automatic t_reset();
    axi_rd(adr(IDX_LOW), 32'h0000_0000, RESP_OKAY);
    axi_rd(adr(IDX_HIGH), 32'h0000_0000, RESP_OKAY);
    axi_rd(adr(IDX_CTRL), 32'h0000_0000, RESP_OKAY);
    exp_map = '0;
    chk_pins(1'b0);
  endtask : t_reset

  // Control bits, then uart on its fixed pins
  task automatic t_uart();
    axi_wr(adr(IDX_CTRL), 32'h0000_00FF, RESP_OKAY);
    axi_rd(adr(IDX_CTRL), 32'h0000_00C0, RESP_OKAY);
    `CHK(weak_dis, 1'b1)
    axi_wr(adr(IDX_CTRL), 32'h0000_0040, RESP_OKAY);
    axi_wr(adr(IDX_LOW), 32'h0000_0001, RESP_OKAY);
    exp_map = '0;
    put_run(4, 1, 2);
    chk_pins(1'b1);
    `CHK(pads[5:0], 6'h0F)
  endtask : t_uart

  // Serif_a and two-wire bus, three-wire then four-wire
  task automatic t_serif_a();
    axi_wr(adr(IDX_LOW), 32'h0000_0006, RESP_OKAY);
    exp_map = '0;
    put_run(0, 7, 3);
    put_run(3, 11, 2);
    chk_pins(1'b1);
    `CHK(open_drain, 15'h0018)
    axi_wr(adr(IDX_MODE), 32'h0000_0001, RESP_OKAY);
    exp_map = '0;
    put_run(0, 7, 4);
    put_run(4, 11, 2);
    chk_pins(1'b1);
    `CHK(open_drain, 15'h0030)
  endtask : t_serif_a

  // Unused bit, serif_b, timer and count inputs, reserved capture field
  task automatic t_high();
    axi_wr(adr(IDX_LOW), 32'h0000_0000, RESP_OKAY);
    axi_wr(adr(IDX_MODE), 32'h0000_0000, RESP_OKAY);
    axi_wr(adr(IDX_HIGH), 32'h0000_00FF, RESP_OKAY);
    axi_rd(adr(IDX_HIGH), 32'h0000_007F, RESP_OKAY);
    exp_map = '0;
    put_run(0, 24, 3);
    put_run(8, 3, 3);
    chk_pins(1'b1);
  endtask : t_high

  // Six capture outputs with four-wire serif_b
  task automatic t_capture();
    axi_wr(adr(IDX_MODE), 32'h0000_0002, RESP_OKAY);
    axi_wr(adr(IDX_HIGH), 32'h0000_0046, RESP_OKAY);
    axi_rd(adr(IDX_MODE), 32'h0000_0002, RESP_OKAY);
    exp_map = '0;
    put_run(0, 18, 6);
    put_run(8, 3, 4);
    chk_pins(1'b1);
  endtask : t_capture

  // Comparators and clock out with the first pin skipped
  task automatic t_cmp();
    axi_wr(adr(IDX_HIGH), 32'h0000_0000, RESP_OKAY);
    axi_wr(adr(IDX_SKIP), 32'h0000_0001, RESP_OKAY);
    axi_wr(adr(IDX_LOW), 32'h0000_00F8, RESP_OKAY);
    exp_map = '0;
    put_run(1, 13, 5);
    chk_pins(1'b1);
  endtask : t_cmp

  // Global enable off releases every pin; the map itself stays
  task automatic t_disable();
    axi_wr(adr(IDX_CTRL), 32'h0000_0000, RESP_OKAY);
    chk_pins(1'b0);
    `CHK(pads, 15'h7FFF)
    // Five pins in use; then every pin skipped, so nothing finds a place
    axi_rd(adr(IDX_STATUS), 32'h0000_0005, RESP_OKAY);
    axi_wr(adr(IDX_SKIP), 32'h0000_7FFF, RESP_OKAY);
    axi_rd(adr(IDX_SKIP), 32'h0000_7FFF, RESP_OKAY);
    axi_rd(adr(IDX_STATUS), 32'h0000_0100, RESP_OKAY);
    exp_map = '0;
    chk_pins(1'b0);
  endtask : t_disable

  task automatic t_unmapped();
    axi_wr(adr(IDX_STATUS), 32'h0000_00FF, RESP_OKAY);
    axi_wr(12'h000, 32'h0000_00FF, RESP_SLVERR);
    axi_rd(12'h000, 32'h0000_0000, RESP_SLVERR);
  endtask : t_unmapped

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_uart();
    t_serif_a();
    t_high();
    t_capture();
    t_cmp();
    t_disable();
    t_unmapped();
    report_and_stop();
  end
endmodule : xrt_crossbar_bench
`default_nettype wire
